// file: common/tws_defs.vh
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH

// register offsets
`define TWS_OFS_DATA 8'h9A
`define TWS_OFS_SADR 8'h9B
`define TWS_OFS_CTRL 8'hE8

// reset values
`define TWS_RST_DATA 8'h00
`define TWS_RST_SADR 8'h55
`define TWS_RST_CTRL 8'h00

// control field positions
`define TWS_BIT_MDO 7
`define TWS_BIT_MDE 6
`define TWS_BIT_MCO 5
`define TWS_BIT_MDI 4
`define TWS_BIT_MSEL 3
`define TWS_BIT_SRST 2
`define TWS_BIT_TXDIR 1
`define TWS_BIT_FLAG 0

// interrupt vector address
`define TWS_IRQ_VECTOR 16'h003B

// spike filter timing
`define TWS_CLK_NS 10
`define TWS_SPIKE_NS 50
// disagreeing samples counted before the sixth lets a level pass (50 ns at 10 ns)
`define TWS_FILT_CYC 3'h5

// slave states
`define TWS_ST_IDLE 4'h0
`define TWS_ST_ADDR 4'h1
`define TWS_ST_AACK 4'h2
`define TWS_ST_HOLD 4'h3
`define TWS_ST_RXBIT 4'h4
`define TWS_ST_RXACK 4'h5
`define TWS_ST_TXBIT 4'h6
`define TWS_ST_TXACK 4'h7
`define TWS_ST_HALT 4'h8
`define TWS_ST_SKIP 4'h9

`endif

// file: hw/tws_core.v
`include "tws_defs.vh"
`default_nettype none

module tws_core (
  input wire mclk,
  input wire rstn,
  input wire [7:0] sfrAddr,
  input wire sfrWr,
  input wire sfrRd,
  input wire [7:0] sfrWdata,
  output reg [7:0] sfrRdata,
  input wire serialPortSelect,
  input wire twowireIrqEnable,
  input wire globalIrqEnable,
  output reg coreIrq,
  output wire [15:0] irqVector,
  input wire serialDataPinIn,
  output wire serialDataPinOut,
  output reg serialDataPinOe,
  input wire serialClockPinIn,
  output wire serialClockPinOut,
  output reg serialClockPinOe
);

  wire [1:0] cleanLines;
  wire sdaF;
  wire sclF;

  // spike filter with synchronisers
  tws_glitch_filter u_filt (
    .mclk(mclk),
    .rstn(rstn),
    .rawIn({serialClockPinIn, serialDataPinIn}),
    .cleanOut(cleanLines)
  );

  assign sdaF = cleanLines[0];
  assign sclF = cleanLines[1];

  // control bits
  reg masterDataOut_q;
  reg masterDataDriveEnable_q;
  reg masterClockOut_q;
  reg masterDataIn_q;
  reg masterSelect_q;
  reg slaveLogicReset_q;
  reg slaveTransmitDirection_q;
  reg byteDoneFlag_q;
  reg [7:0] twowireData_q;
  reg [7:0] twowireSlaveAddress_q;

  // slave engine
  reg [3:0] state_q;
  reg [3:0] bitCnt_q;
  reg [7:0] shift_q;
  reg sdaLow_q;
  reg sclLow_q;
  reg ackSeen_q;
  reg accessed_q;
  reg sclPrev_q;
  reg sdaPrev_q;

  wire sclRise;
  wire sclFall;
  wire startCond;
  wire stopCond;
  wire dataAcc;
  wire ctrlWr;
  wire slaveOn;
  wire flagSet;
  wire flagClr;
  wire haltReq;
  wire byteLoad;

  assign irqVector = `TWS_IRQ_VECTOR;
  assign serialDataPinOut = 1'b0;
  assign serialClockPinOut = 1'b0;

  assign sclRise = sclF & ~sclPrev_q;
  assign sclFall = ~sclF & sclPrev_q;
  assign startCond = sclF & sclPrev_q & sdaPrev_q & ~sdaF;
  assign stopCond = sclF & sclPrev_q & ~sdaPrev_q & sdaF;

  assign dataAcc = (sfrWr | sfrRd) & (sfrAddr == `TWS_OFS_DATA);
  assign ctrlWr = sfrWr & (sfrAddr == `TWS_OFS_CTRL);

  // slave runs only when two-wire selected, not master, not held in reset
  assign slaveOn = ~serialPortSelect & ~masterSelect_q & ~slaveLogicReset_q;

  // address byte or data byte completed with acknowledge; same flag for both
  assign flagSet = slaveOn & sclFall & (state_q != `TWS_ST_HALT) & ~stopCond & ~startCond &
                   ((state_q == `TWS_ST_AACK) | (state_q == `TWS_ST_RXACK) |
                    ((state_q == `TWS_ST_TXACK) & ackSeen_q));
  assign byteLoad = slaveOn & sclFall & (state_q != `TWS_ST_HALT) &
                    ((state_q == `TWS_ST_AACK) | (state_q == `TWS_ST_RXACK));
  assign flagClr = dataAcc | (ctrlWr & ~sfrWdata[`TWS_BIT_FLAG]);
  assign haltReq = slaveOn & dataAcc & ~byteDoneFlag_q & accessed_q;

  // edge detection history
  always @(posedge mclk) begin
    if (!rstn) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclF;
      sdaPrev_q <= sdaF;
    end
  end

  // control register and master mode
  always @(posedge mclk) begin
    if (!rstn) begin
      masterDataOut_q <= 1'b0;
      masterDataDriveEnable_q <= 1'b0;
      masterClockOut_q <= 1'b0;
      masterSelect_q <= 1'b0;
      slaveLogicReset_q <= 1'b0;
      masterDataIn_q <= 1'b0;
    end else begin
      if (ctrlWr) begin
        masterDataOut_q <= sfrWdata[`TWS_BIT_MDO];
        masterDataDriveEnable_q <= sfrWdata[`TWS_BIT_MDE];
        masterClockOut_q <= sfrWdata[`TWS_BIT_MCO];
        masterSelect_q <= sfrWdata[`TWS_BIT_MSEL];
        slaveLogicReset_q <= sfrWdata[`TWS_BIT_SRST];
      end
      if (~serialPortSelect & masterSelect_q & ~masterDataDriveEnable_q & sclRise) begin
        masterDataIn_q <= sdaF;
      end
    end
  end

  // byte flag: hardware set wins over clear
  always @(posedge mclk) begin
    if (!rstn) begin
      byteDoneFlag_q <= 1'b0;
    end else if (flagSet) begin
      byteDoneFlag_q <= 1'b1;
    end else if (flagClr) begin
      byteDoneFlag_q <= 1'b0;
    end
  end

  // one data access allowed per flag
  always @(posedge mclk) begin
    if (!rstn) begin
      accessed_q <= 1'b0;
    end else if (slaveLogicReset_q | flagSet) begin
      accessed_q <= 1'b0;
    end else if (dataAcc) begin
      accessed_q <= 1'b1;
    end
  end

  // data and address registers
  always @(posedge mclk) begin
    if (!rstn) begin
      twowireData_q <= `TWS_RST_DATA;
      twowireSlaveAddress_q <= `TWS_RST_SADR;
    end else begin
      if (byteLoad) begin
        twowireData_q <= shift_q;
      end else if (sfrWr & (sfrAddr == `TWS_OFS_DATA)) begin
        twowireData_q <= sfrWdata;
      end
      if (sfrWr & (sfrAddr == `TWS_OFS_SADR)) begin
        twowireSlaveAddress_q <= sfrWdata;
      end
    end
  end

  // slave state machine
  always @(posedge mclk) begin
    if (!rstn) begin
      state_q <= `TWS_ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      sdaLow_q <= 1'b0;
      sclLow_q <= 1'b0;
      ackSeen_q <= 1'b0;
      slaveTransmitDirection_q <= 1'b0;
    end else if (!slaveOn) begin
      state_q <= `TWS_ST_IDLE;
      bitCnt_q <= 4'h0;
      sdaLow_q <= 1'b0;
      sclLow_q <= 1'b0;
    end else if (haltReq | (state_q == `TWS_ST_HALT)) begin
      state_q <= `TWS_ST_HALT;
      sdaLow_q <= 1'b0;
      sclLow_q <= 1'b0;
    end else if (stopCond) begin
      state_q <= `TWS_ST_IDLE;
      sdaLow_q <= 1'b0;
      sclLow_q <= 1'b0;
    end else if (startCond) begin
      state_q <= `TWS_ST_ADDR;
      bitCnt_q <= 4'h0;
      sdaLow_q <= 1'b0;
      sclLow_q <= 1'b0;
    end else begin
      case (state_q)
        `TWS_ST_ADDR: begin
          if (sclRise) begin
            shift_q <= {shift_q[6:0], sdaF};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall & (bitCnt_q == 4'h8)) begin
            if (shift_q[7:1] == twowireSlaveAddress_q[6:0]) begin
              sdaLow_q <= 1'b1;
              slaveTransmitDirection_q <= shift_q[0];
              state_q <= `TWS_ST_AACK;
            end else begin
              state_q <= `TWS_ST_SKIP;
            end
          end
        end
        `TWS_ST_AACK, `TWS_ST_RXACK: begin
          if (sclFall) begin
            sdaLow_q <= 1'b0;
            sclLow_q <= 1'b1;
            state_q <= `TWS_ST_HOLD;
          end
        end
        `TWS_ST_HOLD: begin
          if (!byteDoneFlag_q) begin
            sclLow_q <= 1'b0;
            if (slaveTransmitDirection_q) begin
              shift_q <= {twowireData_q[6:0], 1'b0};
              sdaLow_q <= ~twowireData_q[7];
              bitCnt_q <= 4'h1;
              state_q <= `TWS_ST_TXBIT;
            end else begin
              bitCnt_q <= 4'h0;
              state_q <= `TWS_ST_RXBIT;
            end
          end
        end
        `TWS_ST_RXBIT: begin
          if (sclRise) begin
            shift_q <= {shift_q[6:0], sdaF};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall & (bitCnt_q == 4'h8)) begin
            sdaLow_q <= 1'b1;
            state_q <= `TWS_ST_RXACK;
          end
        end
        `TWS_ST_TXBIT: begin
          if (sclFall) begin
            if (bitCnt_q == 4'h8) begin
              sdaLow_q <= 1'b0;
              state_q <= `TWS_ST_TXACK;
            end else begin
              sdaLow_q <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
        end
        `TWS_ST_TXACK: begin
          if (sclRise) begin
            ackSeen_q <= ~sdaF;
          end else if (sclFall) begin
            if (ackSeen_q) begin
              sclLow_q <= 1'b1;
              state_q <= `TWS_ST_HOLD;
            end else begin
              state_q <= `TWS_ST_IDLE;
            end
          end
        end
        `TWS_ST_IDLE, `TWS_ST_SKIP: begin
          sdaLow_q <= 1'b0;
          sclLow_q <= 1'b0;
        end
        default: begin
          state_q <= `TWS_ST_IDLE;
        end
      endcase
    end
  end

  // pin drivers, open drain
  always @(posedge mclk) begin
    if (!rstn) begin
      serialDataPinOe <= 1'b0;
      serialClockPinOe <= 1'b0;
    end else if (serialPortSelect) begin
      serialDataPinOe <= 1'b0;
      serialClockPinOe <= 1'b0;
    end else if (masterSelect_q) begin
      serialDataPinOe <= masterDataDriveEnable_q & ~masterDataOut_q;
      serialClockPinOe <= ~masterClockOut_q;
    end else begin
      serialDataPinOe <= sdaLow_q;
      serialClockPinOe <= sclLow_q;
    end
  end

  // core interrupt request
  always @(posedge mclk) begin
    if (!rstn) begin
      coreIrq <= 1'b0;
    end else begin
      coreIrq <= byteDoneFlag_q & twowireIrqEnable & globalIrqEnable;
    end
  end

  // register read port
  always @(posedge mclk) begin
    if (!rstn) begin
      sfrRdata <= 8'h00;
    end else if (sfrRd) begin
      case (sfrAddr)
        `TWS_OFS_DATA: sfrRdata <= twowireData_q;
        `TWS_OFS_SADR: sfrRdata <= twowireSlaveAddress_q;
        `TWS_OFS_CTRL: sfrRdata <= {masterDataOut_q, masterDataDriveEnable_q, masterClockOut_q,
                                    masterDataIn_q, masterSelect_q, slaveLogicReset_q,
                                    slaveTransmitDirection_q, byteDoneFlag_q};
        default: sfrRdata <= 8'h00;
      endcase
    end
  end

endmodule // tws_core

`default_nettype wire

// file: hw/tws_glitch_filter.v
`include "tws_defs.vh"
`default_nettype none

module tws_glitch_filter (
  input wire mclk,
  input wire rstn,
  input wire [1:0] rawIn,
  output wire [1:0] cleanOut
);

  localparam [2:0] FILT_CNT = `TWS_FILT_CYC;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_line
      reg sync1_q;
      reg sync2_q;
      reg out_q;
      reg [2:0] cnt_q;
      // two-stage synchroniser
      always @(posedge mclk) begin
        if (!rstn) begin
          sync1_q <= 1'b1;
          sync2_q <= 1'b1;
        end else begin
          sync1_q <= rawIn[gi];
          sync2_q <= sync1_q;
        end
      end
      // level must stand for the filter time before it passes
      always @(posedge mclk) begin
        if (!rstn) begin
          out_q <= 1'b1;
          cnt_q <= 3'h0;
        end else if (sync2_q == out_q) begin
          cnt_q <= 3'h0;
        end else if (cnt_q == FILT_CNT) begin
          out_q <= sync2_q;
          cnt_q <= 3'h0;
        end else begin
          cnt_q <= cnt_q + 3'h1;
        end
      end
      assign cleanOut[gi] = out_q;
    end
  endgenerate

endmodule // tws_glitch_filter

`default_nettype wire

// file: verification/tb_tws_core.sv
`default_nettype none
module tb_tws_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, sfrWr, sfrRd, psel, ien, gien, ack;
  logic [7:0] sfrAddr, sfrWdata, rd, rx;
  wire logic [7:0] sfrRdata;
  wire logic [15:0] irqVector;
  wire logic coreIrq, sdaOut, sdaOe, sclOut, sclOe, sdaLine, sclLine, mSda, mScl;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  assign sdaLine = !(sdaOe || mSda);
  assign sclLine = !(sclOe || mScl);
  tws_core u_tws_core (.mclk(mclk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .serialPortSelect(psel), .twowireIrqEnable(ien),
    .globalIrqEnable(gien), .coreIrq(coreIrq), .irqVector(irqVector), .serialDataPinIn(sdaLine),
    .serialDataPinOut(sdaOut), .serialDataPinOe(sdaOe), .serialClockPinIn(sclLine),
    .serialClockPinOut(sclOut), .serialClockPinOe(sclOe));
  tws_bus_master_model u_tws_bus_master_model (.sclLine(sclLine), .sdaLine(sdaLine), .sclLow(mScl), .sdaLow(mSda));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = !mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfrWr = 1'b1;
    sfrAddr = a;
    sfrWdata = d;
    tick(1);
    sfrWr = 1'b0;
    tick(1);
  endtask
  task automatic sfr_rd(input logic [7:0] a);
    sfrRd = 1'b1;
    sfrAddr = a;
    tick(1);
    rd = sfrRdata;
    sfrRd = 1'b0;
    tick(1);
  endtask
  task automatic flag(input logic e);
    for (int i = 0; i < 60; i++) begin
      sfr_rd(8'hE8);
      if (rd[0] === 1'b1) break;
    end
    chk("flag", e, rd[0]);
  endtask
  task automatic t_regs();
    sfr_rd(8'h9A);
    chk("data", 8'h00, rd);
    sfr_rd(8'h9B);
    chk("sadr", 8'h55, rd);
    sfr_rd(8'hE8);
    chk("ctrl", 8'h00, rd);
    sfr_rd(8'h00);
    chk("unmapped", 8'h00, rd);
    sfr_wr(8'h9B, 8'h2A);
    sfr_rd(8'h9B);
    chk("sadr wr", 8'h2A, rd);
    $display("t_regs done");
  endtask
  task automatic t_rx();
    u_tws_bus_master_model.start_cond();
    u_tws_bus_master_model.xfer(8'h54, 1'b1, rx, ack);
    chk("addr ack", 8'h01, ack);
    flag(1'b1);
    chk("irq", 8'h01, coreIrq);
    chk("dir rx", 8'h00, rd[1]);
    fork
      u_tws_bus_master_model.xfer(8'hC3, 1'b1, rx, ack);
      begin
        tick(100);
        chk("stretch", 8'h00, sclLine);
        sfr_rd(8'h9A);
        chk("addr byte", 8'h54, rd);
      end
    join
    chk("data ack", 8'h01, ack);
    flag(1'b1);
    sfr_rd(8'h9A);
    chk("rx byte", 8'hC3, rd);
    u_tws_bus_master_model.stop_cond();
    $display("t_rx done");
  endtask
  task automatic t_tx();
    u_tws_bus_master_model.start_cond();
    u_tws_bus_master_model.xfer(8'h55, 1'b1, rx, ack);
    flag(1'b1);
    chk("dir tx", 8'h01, rd[1]);
    sfr_wr(8'h9A, 8'hA5);
    sfr_rd(8'hE8);
    chk("clear", 8'h00, rd[0]);
    u_tws_bus_master_model.xfer(8'hFF, 1'b0, rx, ack);
    chk("tx byte", 8'hA5, rx);
    flag(1'b1);
    sfr_wr(8'h9A, 8'h3C);
    u_tws_bus_master_model.xfer(8'hFF, 1'b1, rx, ack);
    chk("tx last", 8'h3C, rx);
    flag(1'b0);
    u_tws_bus_master_model.stop_cond();
    $display("t_tx done");
  endtask
  task automatic t_miss();
    u_tws_bus_master_model.start_cond();
    u_tws_bus_master_model.xfer(8'hAA, 1'b1, rx, ack);
    chk("miss ack", 8'h00, ack);
    u_tws_bus_master_model.stop_cond();
    $display("t_miss done");
  endtask
  task automatic t_halt();
    u_tws_bus_master_model.start_cond();
    u_tws_bus_master_model.xfer(8'h54, 1'b1, rx, ack);
    flag(1'b1);
    sfr_rd(8'h9A);
    sfr_rd(8'h9A);
    u_tws_bus_master_model.xfer(8'h11, 1'b1, rx, ack);
    chk("halted", 8'h00, ack);
    u_tws_bus_master_model.stop_cond();
    sfr_wr(8'hE8, 8'h04);
    sfr_wr(8'hE8, 8'h00);
    ien = 1'b0;
    u_tws_bus_master_model.start_cond();
    u_tws_bus_master_model.xfer(8'h54, 1'b1, rx, ack);
    chk("resumed", 8'h01, ack);
    flag(1'b1);
    chk("irq gated", 8'h00, coreIrq);
    ien = 1'b1;
    tick(2);
    chk("irq enabled", 8'h01, coreIrq);
    sfr_rd(8'h9A);
    u_tws_bus_master_model.stop_cond();
    $display("t_halt done");
  endtask
  task automatic t_master();
    sfr_wr(8'hE8, 8'h48);
    tick(1);
    chk("sda low", 8'h01, sdaOe);
    chk("scl low", 8'h01, sclOe);
    sfr_wr(8'hE8, 8'hE8);
    tick(1);
    chk("sda high", 8'h00, sdaOe);
    chk("scl high", 8'h00, sclOe);
    for (int v = 0; v < 2; v++) begin
      u_tws_bus_master_model.sdaLow = (v == 0);
      sfr_wr(8'hE8, 8'h08);
      tick(20);
      chk("sda released", 8'h00, sdaOe);
      sfr_wr(8'hE8, 8'h28);
      tick(20);
      sfr_rd(8'hE8);
      chk("mdi", 8'(v), rd[4]);
    end
    sfr_wr(8'hE8, 8'h00);
    $display("t_master done");
  endtask
  initial begin
    rstn = 1'b0;
    sfrWr = 1'b0;
    sfrRd = 1'b0;
    sfrAddr = 8'h00;
    sfrWdata = 8'h00;
    psel = 1'b1;
    ien = 1'b1;
    gien = 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    rstn = 1'b1;
    tick(3);
    psel = 1'b0;
    tick(20);
    t_regs();
    t_rx();
    t_tx();
    t_miss();
    t_halt();
    t_master();
    report_and_stop();
  end
endmodule // tb_tws_core
bind tws_core tws_core_assertions u_tws_core_assertions (.mclk(mclk), .rstn(rstn), .sfrAddr(sfrAddr),
  .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .serialPortSelect(serialPortSelect),
  .twowireIrqEnable(twowireIrqEnable), .globalIrqEnable(globalIrqEnable), .coreIrq(coreIrq),
  .irqVector(irqVector), .serialDataPinIn(serialDataPinIn), .serialDataPinOut(serialDataPinOut),
  .serialDataPinOe(serialDataPinOe), .serialClockPinIn(serialClockPinIn),
  .serialClockPinOut(serialClockPinOut), .serialClockPinOe(serialClockPinOe));
`default_nettype wire

// file: verification/tws_bus_master_model.sv
`default_nettype none
module tws_bus_master_model (
  input wire logic sclLine,
  input wire logic sdaLine,
  output logic sclLow,
  output logic sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // release clock, wait out a stretch of up to 3000 polls of 10 ns
  task automatic rise();
    sclLow = 1'b0;
    #10;
    for (int i = 0; i < 3000 && !sclLine; i++) #10;
    #60;
  endtask
  task automatic start_cond();
    sdaLow = 1'b1;
    #80;
    sclLow = 1'b1;
    #30;
  endtask
  task automatic stop_cond();
    sdaLow = 1'b1;
    #90;
    rise();
    sdaLow = 1'b0;
    #160;
  endtask
  // eight bits msb first, then acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ackBit, output logic [7:0] rx, output logic acked);
    logic [8:0] b;
    logic [8:0] s;
    b = {tx, ackBit};
    for (int i = 8; i >= 0; i--) begin
      // low phase outlasts the slave's filtered response to the fall
      sdaLow = !b[i];
      #90;
      rise();
      s[i] = sdaLine;
      sclLow = 1'b1;
      #30;
    end
    rx = s[8:1];
    acked = !s[0];
  endtask
endmodule // tws_bus_master_model
`default_nettype wire

// file: verification/tws_core_assertions.sv
`default_nettype none
module tws_core_assertions (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  input wire logic serialPortSelect,
  input wire logic twowireIrqEnable,
  input wire logic globalIrqEnable,
  input wire logic coreIrq,
  input wire logic [15:0] irqVector,
  input wire logic serialDataPinIn,
  input wire logic serialDataPinOut,
  input wire logic serialDataPinOe,
  input wire logic serialClockPinIn,
  input wire logic serialClockPinOut,
  input wire logic serialClockPinOe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_VECTOR: assert property (irqVector == 16'h003B)
    else $error("irq vector wrong");
  AST_IRQ_GATE: assert property (coreIrq |-> $past(twowireIrqEnable && globalIrqEnable))
    else $error("irq without both enables");
  AST_OPEN_DRAIN: assert property (!serialDataPinOut && !serialClockPinOut)
    else $error("pin driven high");
  AST_SELECT: assert property (serialPortSelect [*2] |-> !serialDataPinOe && !serialClockPinOe)
    else $error("pins driven while deselected");
  AST_RESET: assert property ($rose(rstn) |-> !coreIrq && !serialDataPinOe && !serialClockPinOe)
    else $error("outputs active after reset");
  AST_SADR_RW: assert property (sfrWr && sfrAddr == 8'h9B ##2 sfrRd && sfrAddr == 8'h9B
    |=> sfrRdata == $past(sfrWdata, 3)) else $error("slave address readback wrong");
  AST_DATA_CLEARS: assert property ((sfrWr || sfrRd) && sfrAddr == 8'h9A ##2 sfrRd && sfrAddr == 8'hE8
    |=> !sfrRdata[0]) else $error("flag not cleared by data access");
  AST_STRETCH: assert property ((serialClockPinOe && !sfrWr && !sfrRd && !serialPortSelect) [*3]
    |=> serialClockPinOe) else $error("clock released without access");
  cover property (coreIrq);
  cover property ($fell(serialClockPinOe));
  cover property (serialDataPinOe && !serialClockPinOe);
endmodule // tws_core_assertions
`default_nettype wire
